// File: pkg/wut_pkg.sv
// Constants and types shared by the wake-up timer and duty-cycle logic.
// Assumes command words arrive whole from a serial deserialiser on CLOCK_IN.
package wut_pkg;

    // Clock and millisecond time base
    localparam int CLK_PERIOD_NS = 10;
    localparam int MS_TIME_NS = 1000000;
    localparam int MS_TICK_CYCLES = MS_TIME_NS / CLK_PERIOD_NS;

    // Command word layout
    localparam int CMD_W = 16;
    localparam int PREFIX_HI = 15;
    localparam int PREFIX_LO = 13;
    localparam int CODE_HI = 15;
    localparam int CODE_LO = 8;
    localparam logic [2:0] WAKE_CMD_PREFIX = 3'h7;
    localparam logic [7:0] DUTY_CMD_CODE = 8'hC8;

    // Period register fields
    localparam int EXP_HI = 12;
    localparam int EXP_LO = 8;
    localparam int EXP_W = 5;
    localparam int MULT_HI = 7;
    localparam int MULT_LO = 0;
    localparam int MULT_W = 8;

    // Duty register fields
    localparam int DVAL_HI = 7;
    localparam int DVAL_LO = 1;
    localparam int DVAL_W = 7;
    localparam int DUTY_EN_BIT = 0;

    // Reset values
    localparam logic [15:0] WAKE_PERIOD_RESET = 16'hE196;
    localparam logic [15:0] DUTY_CONFIG_RESET = 16'hC80E;

    // Widest interval in ms: 255 * 2^31
    localparam int INTERVAL_W = MULT_W + 31;

    typedef enum logic [3:0] {
        WUT_IDLE = 4'b0001,
        WUT_SLEEP = 4'b0010,
        WUT_RX_ON = 4'b0100,
        WUT_EXPIRED = 4'b1000
    } wut_state_e;

endpackage

// File: verilog/wut_down_counter.sv
// Loadable millisecond down-counter with a registered expiry pulse.
// Assumes tick_in is a one-cycle enable on the same clock.
`timescale 1ns/1ps
`default_nettype none
module wut_down_counter #(
    parameter int WIDTH = 39
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic load_in,
    input wire logic [WIDTH-1:0] value_in,
    input wire logic tick_in,
    output logic [WIDTH-1:0] count_out,
    output logic done_out
);
    logic [WIDTH-1:0] count_r;
    logic done_r;
    wire last_w = tick_in && (count_r == WIDTH'(1));
    wire step_w = tick_in && (count_r != '0);

    // Zero load never expires
    always_ff @(posedge clk_in) begin
        if (rst_in || load_in) begin
            count_r <= rst_in ? '0 : value_in;
        end else if (step_w) begin
            count_r <= count_r - WIDTH'(1);
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in || load_in) begin
            done_r <= 1'b0;
        end else begin
            done_r <= last_w;
        end
    end

    assign count_out = count_r;
    assign done_out = done_r;
endmodule
`default_nettype wire

// File: verilog/wut_wake_timer.sv
// Wake-up timer with receiver duty-cycle window, fed by 16-bit commands.
// Assumes commands and power-management bits come from CLOCK_IN logic.
`timescale 1ns/1ps
`default_nettype none
module wut_wake_timer
    import wut_pkg::*;
#(
    parameter int MS_CYCLES = MS_TICK_CYCLES
) (
    input wire logic CLOCK_IN,
    input wire logic RST_IN,
    input wire logic [CMD_W-1:0] CMD_WORD_IN,
    input wire logic CMD_VALID_IN,
    input wire logic WAKE_TIMER_ENABLE_IN,
    input wire logic RECEIVER_CHAIN_ENABLE_IN,
    output logic [CMD_W-1:0] WAKE_PERIOD_OUT,
    output logic [CMD_W-1:0] DUTY_CONFIG_OUT,
    output logic WAKE_EVENT_OUT,
    output logic RX_ENABLE_OUT,
    output logic SLEEP_OUT
);
    localparam int IW = INTERVAL_W;
    localparam int DIV_W = $clog2(MS_CYCLES + 1);

    logic [CMD_W-1:0] wake_period_config_r;
    logic [CMD_W-1:0] rx_duty_cycle_config_r;
    logic wake_en_prev_r;
    logic [DIV_W-1:0] div_r;
    wut_state_e state_r;
    wut_state_e state_nxt;
    logic wake_evt_r;
    logic rx_en_r;
    logic sleep_r;
    logic [IW-1:0] sleep_cnt;
    logic [IW-1:0] on_cnt;
    logic sleep_done;
    logic on_done;

    // Command decode
    wire wake_cmd = CMD_WORD_IN[PREFIX_HI:PREFIX_LO] == WAKE_CMD_PREFIX;
    wire duty_cmd = CMD_WORD_IN[CODE_HI:CODE_LO] == DUTY_CMD_CODE;
    wire wake_wr = CMD_VALID_IN && wake_cmd;
    wire duty_wr = CMD_VALID_IN && duty_cmd;

    // Field extraction
    wire [EXP_W-1:0] exp_val = wake_period_config_r[EXP_HI:EXP_LO];
    wire [MULT_W-1:0] mult_val = wake_period_config_r[MULT_HI:MULT_LO];
    wire [DVAL_W-1:0] duty_val = rx_duty_cycle_config_r[DVAL_HI:DVAL_LO];
    wire duty_mode_enable = rx_duty_cycle_config_r[DUTY_EN_BIT];

    // Interval and on-time in ms ticks
    wire [IW-1:0] interval_ms = IW'(mult_val) << exp_val;
    wire [IW-1:0] on_time_ms = IW'({duty_val, 1'b1}) << exp_val;

    wire wake_timer_enable = WAKE_TIMER_ENABLE_IN;
    wire wake_rise = wake_timer_enable && !wake_en_prev_r;

    // State predicates
    wire in_idle = state_r == WUT_IDLE;
    wire in_sleep = state_r == WUT_SLEEP;
    wire in_rx_on = state_r == WUT_RX_ON;
    wire expire = in_sleep && wake_timer_enable && sleep_done;
    wire window_end = in_rx_on && wake_timer_enable && on_done;

    // Reload on rearm and at each duty window end
    wire sleep_load = (in_idle && wake_rise) || window_end;
    wire on_load = expire && duty_mode_enable;

    wire div_last = div_r == DIV_W'(MS_CYCLES - 1);
    wire ms_tick = div_last;

    // Period register, written by its command
    always_ff @(posedge CLOCK_IN) begin
        if (RST_IN) begin
            wake_period_config_r <= WAKE_PERIOD_RESET;
        end else if (wake_wr) begin
            wake_period_config_r <= CMD_WORD_IN;
        end
    end

    // Duty register, written by its command
    always_ff @(posedge CLOCK_IN) begin
        if (RST_IN) begin
            rx_duty_cycle_config_r <= DUTY_CONFIG_RESET;
        end else if (duty_wr) begin
            rx_duty_cycle_config_r <= CMD_WORD_IN;
        end
    end

    always_ff @(posedge CLOCK_IN) begin
        if (RST_IN) begin
            wake_en_prev_r <= 1'b0;
        end else begin
            wake_en_prev_r <= wake_timer_enable;
        end
    end

    // Millisecond divider, restarted with each interval load
    always_ff @(posedge CLOCK_IN) begin
        if (RST_IN || sleep_load || in_idle) begin
            div_r <= '0;
        end else if (div_last) begin
            div_r <= '0;
        end else begin
            div_r <= div_r + DIV_W'(1);
        end
    end

    wut_down_counter #(
        .WIDTH(IW)
    ) u_sleep_cnt (
        .clk_in(CLOCK_IN),
        .rst_in(RST_IN),
        .load_in(sleep_load),
        .value_in(interval_ms),
        .tick_in(ms_tick),
        .count_out(sleep_cnt),
        .done_out(sleep_done)
    );

    wut_down_counter #(
        .WIDTH(IW)
    ) u_on_cnt (
        .clk_in(CLOCK_IN),
        .rst_in(RST_IN),
        .load_in(on_load),
        .value_in(on_time_ms),
        .tick_in(ms_tick),
        .count_out(on_cnt),
        .done_out(on_done)
    );

    // Sequencer
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            WUT_IDLE: begin
                if (wake_rise) begin
                    state_nxt = WUT_SLEEP;
                end
            end
            WUT_SLEEP: begin
                if (!wake_timer_enable) begin
                    state_nxt = WUT_IDLE;
                end else if (sleep_done) begin
                    state_nxt = duty_mode_enable ? WUT_RX_ON : WUT_EXPIRED;
                end
            end
            WUT_RX_ON: begin
                if (!wake_timer_enable) begin
                    state_nxt = WUT_IDLE;
                end else if (on_done) begin
                    state_nxt = WUT_SLEEP;
                end
            end
            WUT_EXPIRED: begin
                // Waits for the host to clear and set the enable
                if (!wake_timer_enable) begin
                    state_nxt = WUT_IDLE;
                end
            end
            default: begin
                state_nxt = WUT_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLOCK_IN) begin
        if (RST_IN) begin
            state_r <= WUT_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Registered outputs
    wire rx_nxt = RECEIVER_CHAIN_ENABLE_IN || (state_nxt == WUT_RX_ON);

    always_ff @(posedge CLOCK_IN) begin
        if (RST_IN) begin
            wake_evt_r <= 1'b0;
            rx_en_r <= 1'b0;
            sleep_r <= 1'b1;
        end else begin
            wake_evt_r <= expire;
            rx_en_r <= rx_nxt;
            sleep_r <= !rx_nxt;
        end
    end

    assign WAKE_PERIOD_OUT = wake_period_config_r;
    assign DUTY_CONFIG_OUT = rx_duty_cycle_config_r;
    assign WAKE_EVENT_OUT = wake_evt_r;
    assign RX_ENABLE_OUT = rx_en_r;
    assign SLEEP_OUT = sleep_r;

    // Checks
    default clocking cb @(posedge CLOCK_IN);
    endclocking
    default disable iff (RST_IN);

    sequence s_wake_write;
        CMD_VALID_IN && CMD_WORD_IN[PREFIX_HI:PREFIX_LO] == 3'h7;
    endsequence

    sequence s_duty_write;
        CMD_VALID_IN && CMD_WORD_IN[CODE_HI:CODE_LO] == 8'hC8;
    endsequence

    sequence s_duty_expire;
        in_sleep && wake_timer_enable && sleep_done && duty_mode_enable;
    endsequence

    sequence s_window_close;
        in_rx_on && wake_timer_enable && on_done;
    endsequence

    property p_wake_write;
        s_wake_write |=> WAKE_PERIOD_OUT == $past(CMD_WORD_IN);
    endproperty
    a_wake_write: assert property (p_wake_write)
        else $error("period write not stored");

    property p_exp_field;
        s_wake_write |=> exp_val == $past(CMD_WORD_IN[12:8]);
    endproperty
    a_exp_field: assert property (p_exp_field)
        else $error("exponent field wrong");

    property p_mult_field;
        s_wake_write |=> mult_val == $past(CMD_WORD_IN[7:0]);
    endproperty
    a_mult_field: assert property (p_mult_field)
        else $error("multiplier field wrong");

    property p_interval;
        sleep_load |=> sleep_cnt == $past(interval_ms);
    endproperty
    a_interval: assert property (p_interval)
        else $error("interval load wrong");

    property p_wake_reset;
        @(posedge CLOCK_IN) disable iff (1'b0)
        RST_IN |=> WAKE_PERIOD_OUT == 16'hE196;
    endproperty
    a_wake_reset: assert property (p_wake_reset)
        else $error("period reset value wrong");

    property p_duty_write;
        s_duty_write |=> DUTY_CONFIG_OUT == $past(CMD_WORD_IN);
    endproperty
    a_duty_write: assert property (p_duty_write)
        else $error("duty write not stored");

    property p_on_time;
        s_duty_expire |=> on_cnt == $past(on_time_ms);
    endproperty
    a_on_time: assert property (p_on_time)
        else $error("on-time load wrong");

    property p_no_duty;
        in_sleep && wake_timer_enable && sleep_done && !duty_mode_enable
            |=> state_r == WUT_EXPIRED && !in_rx_on;
    endproperty
    a_no_duty: assert property (p_no_duty)
        else $error("window opened with duty mode off");

    property p_duty_cycle;
        s_duty_expire |=> in_rx_on && RX_ENABLE_OUT && WAKE_EVENT_OUT;
    endproperty
    a_duty_cycle: assert property (p_duty_cycle)
        else $error("expiry did not open receiver window");

    property p_back_to_sleep;
        s_window_close |=> in_sleep ##0 (sleep_cnt == $past(interval_ms));
    endproperty
    a_back_to_sleep: assert property (p_back_to_sleep)
        else $error("window end did not rearm sleep");

    property p_duty_reset;
        @(posedge CLOCK_IN) disable iff (1'b0)
        RST_IN |=> DUTY_CONFIG_OUT == 16'hC80E && !duty_mode_enable;
    endproperty
    a_duty_reset: assert property (p_duty_reset)
        else $error("duty reset value wrong");

    property p_enable_gate;
        !wake_timer_enable |=> in_idle ##1 (in_idle || $past(wake_timer_enable));
    endproperty
    a_enable_gate: assert property (p_enable_gate)
        else $error("timer ran while disabled");

    property p_tick_spacing;
        ms_tick && !sleep_load |=> !ms_tick && div_r == '0;
    endproperty
    a_tick_spacing: assert property (p_tick_spacing)
        else $error("ms tick malformed");

    property p_window_off;
        s_window_close ##0 !RECEIVER_CHAIN_ENABLE_IN [*2] |-> !RX_ENABLE_OUT && SLEEP_OUT;
    endproperty
    a_window_off: assert property (p_window_off)
        else $error("receiver left on after window");
endmodule
`default_nettype wire

// File: sim/wut_host_model.sv
// Host side model: writes whole command words and drives the power bits.
// Assumes the timer samples its inputs on the rising edge of clk_in.
`timescale 1ns/1ps
`default_nettype none
module wut_host_model
    import wut_pkg::*;
(
    input wire logic clk_in,
    output logic [CMD_W-1:0] cmd_word_out,
    output logic cmd_valid_out,
    output logic wake_en_out,
    output logic rx_chain_en_out
);
    initial begin
        cmd_word_out = 16'h0000;
        cmd_valid_out = 1'b0;
        wake_en_out = 1'b0;
        rx_chain_en_out = 1'b0;
    end
    // One whole word, valid for a single cycle, then the bus is scrambled
    task automatic send_word(input logic [CMD_W-1:0] w);
        @(posedge clk_in) #1;
        cmd_word_out = w;
        cmd_valid_out = 1'b1;
        @(posedge clk_in) #1;
        cmd_valid_out = 1'b0;
        cmd_word_out = ~w;
    endtask
    // Clear then set the timer enable, receiver enable kept low
    task automatic rearm();
        @(posedge clk_in) #1;
        wake_en_out = 1'b0;
        rx_chain_en_out = 1'b0;
        @(posedge clk_in) #1;
        wake_en_out = 1'b1;
    endtask
    task automatic set_power(input logic wk, input logic rx);
        @(posedge clk_in) #1;
        wake_en_out = wk;
        rx_chain_en_out = rx;
    endtask
endmodule
`default_nettype wire

// File: sim/tb_wut_wake_timer.sv
// Self-checking bench for the wake-up timer and duty-cycle logic.
// Assumes a short millisecond divider so intervals stay a few cycles.
`timescale 1ns/1ps
`default_nettype none
module tb_wut_wake_timer;
    import wut_pkg::*;
    localparam int MS = 4;
    logic clk;
    logic rst;
    logic [CMD_W-1:0] cmd_word;
    logic cmd_valid;
    logic wake_en;
    logic rx_chain_en;
    logic [CMD_W-1:0] period;
    logic [CMD_W-1:0] duty;
    logic wake_event;
    logic rx_en;
    logic sleep;
    int errors = 0;
    int checks_done = 0;
    int cycles = 0;

    wut_wake_timer #(.MS_CYCLES(MS)) i_wut_wake_timer (
        .CLOCK_IN(clk), .RST_IN(rst), .CMD_WORD_IN(cmd_word), .CMD_VALID_IN(cmd_valid),
        .WAKE_TIMER_ENABLE_IN(wake_en), .RECEIVER_CHAIN_ENABLE_IN(rx_chain_en),
        .WAKE_PERIOD_OUT(period), .DUTY_CONFIG_OUT(duty), .WAKE_EVENT_OUT(wake_event),
        .RX_ENABLE_OUT(rx_en), .SLEEP_OUT(sleep));
    wut_host_model i_wut_host_model (
        .clk_in(clk), .cmd_word_out(cmd_word), .cmd_valid_out(cmd_valid),
        .wake_en_out(wake_en), .rx_chain_en_out(rx_chain_en));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            errors++;
            wrap_up();
        end
    end

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic check_range(input string what, input int lo, input int hi, input int got);
        checks_done++;
        if (got < lo || got > hi) begin
            errors++;
            $display("CHECK FAILED %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask
    // Cycles until a wake pulse, or limit if none
    task automatic wait_event(input int limit, output int n);
        n = 0;
        while (wake_event !== 1'b1 && n < limit) begin
            @(posedge clk) #1;
            n++;
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic t_reset_and_decode();
        check("period reset", 16'hE196, period);
        check("duty reset", 16'hC80E, duty);
        check("rx reset", 16'h0000, {15'h0000, rx_en});
        check("sleep reset", 16'h0001, {15'h0000, sleep});
        i_wut_host_model.send_word(16'hFFFF);
        check("period max fields", 16'hFFFF, period);
        i_wut_host_model.send_word(16'hE000);
        check("period zero fields", 16'hE000, period);
        i_wut_host_model.send_word(16'hC623);
        i_wut_host_model.send_word(16'hC80F);
        check("duty write", 16'hC80F, duty);
        i_wut_host_model.send_word(16'hC9FF);
        check("period kept", 16'hE000, period);
        check("duty kept", 16'hC80F, duty);
        i_wut_host_model.send_word(16'hC80E);
        check("duty mode off", 16'hC80E, duty);
        i_wut_host_model.set_power(1'b0, 1'b1);
        repeat (2) @(posedge clk);
        #1;
        check("rx chain on", 16'h0001, {15'h0000, rx_en});
        i_wut_host_model.set_power(1'b0, 1'b0);
        $display("test reset_and_decode done");
    endtask

    task automatic t_interval();
        logic [15:0] words [3] = '{16'hE103, 16'hE202, 16'hE005};
        int iv [3] = '{6, 8, 5};
        int n;
        for (int i = 0; i < 3; i++) begin
            i_wut_host_model.send_word(words[i]);
            i_wut_host_model.rearm();
            wait_event(iv[i] * MS + MS + 8, n);
            check_range("interval cycles", iv[i] * MS, iv[i] * MS + MS + 4, n);
            check("no window in timer mode", 16'h0000, {15'h0000, rx_en});
            @(posedge clk) #1;
            check("event one cycle", 16'h0000, {15'h0000, wake_event});
        end
        wait_event(3 * iv[2] * MS, n);
        check_range("no repeat without rearm", 3 * iv[2] * MS, 3 * iv[2] * MS, n);
        i_wut_host_model.rearm();
        repeat (2 * MS) @(posedge clk);
        i_wut_host_model.set_power(1'b0, 1'b0);
        wait_event(3 * iv[2] * MS, n);
        check_range("stopped by enable low", 3 * iv[2] * MS, 3 * iv[2] * MS, n);
        i_wut_host_model.send_word(16'hE000);
        i_wut_host_model.rearm();
        wait_event(20 * MS, n);
        check_range("zero multiplier", 20 * MS, 20 * MS, n);
        $display("test interval done");
    endtask

    task automatic t_duty();
        int n;
        i_wut_host_model.send_word(16'hE102);
        i_wut_host_model.send_word(16'hC803);
        i_wut_host_model.rearm();
        for (int k = 0; k < 2; k++) begin
            wait_event(2 * MS + MS + 8 + 3 * MS + 8, n);
            check("wake seen", 16'h0001, {15'h0000, wake_event});
            check("rx on at wake", 16'h0001, {15'h0000, rx_en});
            n = 0;
            while (rx_en === 1'b1 && n < 10 * MS) begin
                if (sleep !== 1'b0)
                    check("sleep in window", 16'h0000, {15'h0000, sleep});
                @(posedge clk) #1;
                n++;
            end
            check_range("on time", 6 * MS - 2, 6 * MS + MS + 2, n);
            check("asleep after", 16'h0001, {15'h0000, sleep});
        end
        i_wut_host_model.set_power(1'b0, 1'b0);
        $display("test duty done");
    endtask

    initial begin
        rst = 1'b1;
        repeat (8) @(posedge clk);
        #1;
        rst = 1'b0;
        t_reset_and_decode();
        t_interval();
        t_duty();
        wrap_up();
    end
endmodule
`default_nettype wire
